// File: rtl/mcirq_params.svh
// Register map, field positions and codes of the measurement control block
`ifndef MCIRQ_PARAMS_SVH
`define MCIRQ_PARAMS_SVH

`define MCIRQ_ADDR_INT_EN     7'h02
`define MCIRQ_ADDR_INT_REQ    7'h03
`define MCIRQ_ADDR_PD_UNLOCK  7'h04
`define MCIRQ_ADDR_PD_CTRL    7'h05
`define MCIRQ_ADDR_CELL       7'h06
`define MCIRQ_ADDR_TEMP       7'h07
`define MCIRQ_ADDR_REGU       7'h08
`define MCIRQ_ADDR_RES_FIRST  7'h20
`define MCIRQ_ADDR_RES_LAST   7'h49

`define MCIRQ_INT_EN_RST      8'h80
`define MCIRQ_INT_REQ_RST     8'h00
`define MCIRQ_CTRL_RST        8'h00
`define MCIRQ_UNLOCK_CODE1    8'h55
`define MCIRQ_UNLOCK_CODE2    8'hAA
`define MCIRQ_FLAG_SW_MASK    8'h7F

`define MCIRQ_FLG_CELL        0
`define MCIRQ_FLG_TEMP        1
`define MCIRQ_FLG_REGU        2
`define MCIRQ_FLG_ID          3
`define MCIRQ_FLG_CRC         4
`define MCIRQ_FLG_DROP        5
`define MCIRQ_FLG_RETURN      6
`define MCIRQ_FLG_WDOV        7

`define MCIRQ_GO_BIT          7
`define MCIRQ_SCAN_BIT        4
`define MCIRQ_PD_BIT          0

`define MCIRQ_RES_TEMP_BASE   5'h10
`define MCIRQ_RES_REGU        5'h14
`define MCIRQ_RES_WORDS       21

`endif

// File: rtl/mcirq_pkg.sv
// Types shared by the measurement control block
package mcirq_pkg;

  typedef enum logic [2:0] {
    MCIRQ_ST_IDLE = 3'b001,
    MCIRQ_ST_REQ  = 3'b010,
    MCIRQ_ST_WAIT = 3'b100
  } mcirq_state_t;

  typedef enum logic [2:0] {
    MCIRQ_UL_NONE  = 3'b001,
    MCIRQ_UL_FIRST = 3'b010,
    MCIRQ_UL_ARMED = 3'b100
  } mcirq_unlock_t;

  typedef enum logic [1:0] {
    MCIRQ_KIND_CELL = 2'h0,
    MCIRQ_KIND_TEMP = 2'h1,
    MCIRQ_KIND_REGU = 2'h2
  } mcirq_kind_t;

endpackage

// File: rtl/mcirq_regs.sv
// Interrupt flags, power-down unlock and measurement control registers
// Operation
// - Flags set on events regardless of enables
// - Interrupt pin low while enabled flag set
// - Write zero clears flag except watchdog, one keeps
// - Pin released once enabled flags cleared
// - Eight flags in fixed bit order
// - Drop flag only on new drop after return
// - Return flag set leaving drop state
// - Power-down needs 55h then AAh unlock
// - Power-down bit one means power-down
// - Single mode measures cell k+1 only
// - Scan mode measures cells 1..k+1
// - Cell go bit starts, reads busy
// - Cell stop waits for current conversion
// - Cell settings frozen while measuring
// - Cell start ignored during other measurement
// - Cell results as byte pairs 20h-3Fh
// - Temperature single or scan channel select
// - Temperature go bit, results 40h-47h
// - Temperature stop waits for current channel
// - Temperature settings frozen while measuring
// - Temperature start ignored during other measurement
// - Regulator measurement converts half voltage
// - Regulator stop ignored, start needs idle
// - CRC error sets flag, drops write
// - Enable register, only watchdog enable set
`timescale 1ns/1ps
`include "mcirq_params.svh"

module mcirq_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register access from the serial link
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        crc_err,
  // Event sources
  input  wire logic        id_done,
  input  wire logic        wdt_overflow,
  input  wire logic        regulator_drop_pin,
  input  wire logic        open_short_busy,
  // Converter handshake
  output logic             adc_req,
  output logic      [1:0]  adc_kind,
  output logic      [3:0]  adc_chan,
  output logic             adc_half,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_data,
  // Device pins and controls
  output logic             int_n_o,
  output logic             int_n_oe,
  output logic             power_down_bit
);

  mcirq_pkg::mcirq_state_t  state_ff,  nxt_state;
  mcirq_pkg::mcirq_unlock_t unlock_ff, nxt_unlock;
  mcirq_pkg::mcirq_kind_t   kind_ff,   nxt_kind;
  logic [7:0]  int_en_ff,   nxt_int_en;
  logic [7:0]  flags_ff,    nxt_flags;
  logic [4:0]  cell_cfg_ff, nxt_cell_cfg;
  logic [2:0]  temp_cfg_ff, nxt_temp_cfg;
  logic [3:0]  chan_ff,     nxt_chan;
  logic [3:0]  last_ff,     nxt_last;
  logic        stop_ff,     nxt_stop;
  logic        pd_ff,       nxt_pd;
  logic        int_oe_ff,   nxt_int_oe;
  logic [7:0]  rdata_ff,    nxt_rdata;
  logic        drop_meta_ff, drop_sync_ff, drop_prev_ff;
  logic [15:0] res_mem [`MCIRQ_RES_WORDS];
  logic [4:0]  mem_idx, rd_idx;
  logic [6:0]  rd_off;
  logic        mem_we, wr_ok, busy, seq_end;
  logic        cell_busy, temp_busy, regu_busy;
  logic [7:0]  set_v, keep_v;

  // Drop detector comes from the analog side, so it is synchronised first
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drop_meta_ff <= 1'b0;
      drop_sync_ff <= 1'b0;
      drop_prev_ff <= 1'b0;
    end else begin
      drop_meta_ff <= regulator_drop_pin;
      drop_sync_ff <= drop_meta_ff;
      drop_prev_ff <= drop_sync_ff;
    end
  end

  assign wr_ok     = reg_wr_en & ~crc_err;
  assign busy      = (state_ff != mcirq_pkg::MCIRQ_ST_IDLE);
  assign cell_busy = busy & (kind_ff == mcirq_pkg::MCIRQ_KIND_CELL);
  assign temp_busy = busy & (kind_ff == mcirq_pkg::MCIRQ_KIND_TEMP);
  assign regu_busy = busy & (kind_ff == mcirq_pkg::MCIRQ_KIND_REGU);
  assign seq_end   = (state_ff == mcirq_pkg::MCIRQ_ST_WAIT) & adc_done
                     & (stop_ff | (chan_ff == last_ff));

  // Measurement sequencer and configuration
  always_comb begin
    nxt_state    = state_ff;
    nxt_kind     = kind_ff;
    nxt_chan     = chan_ff;
    nxt_last     = last_ff;
    nxt_stop     = stop_ff;
    nxt_cell_cfg = cell_cfg_ff;
    nxt_temp_cfg = temp_cfg_ff;
    mem_we       = 1'b0;
    mem_idx      = 5'h00;
    if (wr_ok && reg_addr == `MCIRQ_ADDR_CELL) begin
      if (!cell_busy) begin
        nxt_cell_cfg = reg_wdata[4:0];
      end else if (!reg_wdata[`MCIRQ_GO_BIT]) begin
        nxt_stop = 1'b1;
      end
    end
    if (wr_ok && reg_addr == `MCIRQ_ADDR_TEMP) begin
      if (!temp_busy) begin
        nxt_temp_cfg = {reg_wdata[`MCIRQ_SCAN_BIT], reg_wdata[1:0]};
      end else if (!reg_wdata[`MCIRQ_GO_BIT]) begin
        nxt_stop = 1'b1;
      end
    end
    // A stop write to the regulator register has no effect
    case (state_ff)
      mcirq_pkg::MCIRQ_ST_IDLE: begin
        // Open/short runs outside this block but still excludes the others
        if (wr_ok && reg_wdata[`MCIRQ_GO_BIT] && !open_short_busy) begin
          if (reg_addr == `MCIRQ_ADDR_CELL) begin
            nxt_state = mcirq_pkg::MCIRQ_ST_REQ;
            nxt_kind  = mcirq_pkg::MCIRQ_KIND_CELL;
            nxt_stop  = 1'b0;
            nxt_last  = reg_wdata[3:0];
            nxt_chan  = reg_wdata[`MCIRQ_SCAN_BIT] ? 4'h0 : reg_wdata[3:0];
          end else if (reg_addr == `MCIRQ_ADDR_TEMP) begin
            nxt_state = mcirq_pkg::MCIRQ_ST_REQ;
            nxt_kind  = mcirq_pkg::MCIRQ_KIND_TEMP;
            nxt_stop  = 1'b0;
            nxt_last  = {2'b00, reg_wdata[1:0]};
            nxt_chan  = reg_wdata[`MCIRQ_SCAN_BIT] ? 4'h0 : {2'b00, reg_wdata[1:0]};
          end else if (reg_addr == `MCIRQ_ADDR_REGU) begin
            nxt_state = mcirq_pkg::MCIRQ_ST_REQ;
            nxt_kind  = mcirq_pkg::MCIRQ_KIND_REGU;
            nxt_stop  = 1'b0;
            nxt_last  = 4'h0;
            nxt_chan  = 4'h0;
          end
        end
      end
      mcirq_pkg::MCIRQ_ST_REQ: begin
        nxt_state = mcirq_pkg::MCIRQ_ST_WAIT;
      end
      mcirq_pkg::MCIRQ_ST_WAIT: begin
        if (adc_done) begin
          mem_we = 1'b1;
          case (kind_ff)
            mcirq_pkg::MCIRQ_KIND_CELL: mem_idx = {1'b0, chan_ff};
            mcirq_pkg::MCIRQ_KIND_TEMP: mem_idx = `MCIRQ_RES_TEMP_BASE + {3'b000, chan_ff[1:0]};
            default:                    mem_idx = `MCIRQ_RES_REGU;
          endcase
          if (seq_end) begin
            nxt_state = mcirq_pkg::MCIRQ_ST_IDLE;
            nxt_stop  = 1'b0;
          end else begin
            nxt_chan  = chan_ff + 4'h1;
            nxt_state = mcirq_pkg::MCIRQ_ST_REQ;
          end
        end
      end
      default: begin
        nxt_state = mcirq_pkg::MCIRQ_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= mcirq_pkg::MCIRQ_ST_IDLE;
      kind_ff     <= mcirq_pkg::MCIRQ_KIND_CELL;
      chan_ff     <= 4'h0;
      last_ff     <= 4'h0;
      stop_ff     <= 1'b0;
      cell_cfg_ff <= 5'h00;
      temp_cfg_ff <= 3'h0;
    end else begin
      state_ff    <= nxt_state;
      kind_ff     <= nxt_kind;
      chan_ff     <= nxt_chan;
      last_ff     <= nxt_last;
      stop_ff     <= nxt_stop;
      cell_cfg_ff <= nxt_cell_cfg;
      temp_cfg_ff <= nxt_temp_cfg;
    end
  end

  // Result words, cleared at reset so unread pairs show zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `MCIRQ_RES_WORDS; i++) begin
        res_mem[i] <= 16'h0000;
      end
    end else if (mem_we) begin
      res_mem[mem_idx] <= adc_data;
    end
  end

  assign adc_req  = (state_ff == mcirq_pkg::MCIRQ_ST_REQ);
  assign adc_kind = kind_ff;
  assign adc_chan = chan_ff;
  assign adc_half = (kind_ff == mcirq_pkg::MCIRQ_KIND_REGU);

  // Flag sources
  always_comb begin
    set_v                     = 8'h00;
    set_v[`MCIRQ_FLG_CELL]    = seq_end & (kind_ff == mcirq_pkg::MCIRQ_KIND_CELL);
    set_v[`MCIRQ_FLG_TEMP]    = seq_end & (kind_ff == mcirq_pkg::MCIRQ_KIND_TEMP);
    set_v[`MCIRQ_FLG_REGU]    = seq_end & (kind_ff == mcirq_pkg::MCIRQ_KIND_REGU);
    set_v[`MCIRQ_FLG_ID]      = id_done;
    set_v[`MCIRQ_FLG_CRC]     = crc_err;
    set_v[`MCIRQ_FLG_DROP]    = drop_sync_ff & ~drop_prev_ff;
    set_v[`MCIRQ_FLG_RETURN]  = ~drop_sync_ff & drop_prev_ff;
    set_v[`MCIRQ_FLG_WDOV]    = wdt_overflow;
    keep_v = 8'hFF;
    if (wr_ok && reg_addr == `MCIRQ_ADDR_INT_REQ) begin
      // Watchdog flag is read-only to software
      keep_v = reg_wdata | ~`MCIRQ_FLAG_SW_MASK;
    end
  end

  // Interrupt, enable, unlock and power-down registers
  always_comb begin
    nxt_flags  = (flags_ff & keep_v) | set_v;
    nxt_int_en = int_en_ff;
    nxt_unlock = unlock_ff;
    nxt_pd     = pd_ff;
    if (wr_ok && reg_addr == `MCIRQ_ADDR_INT_EN) begin
      nxt_int_en = reg_wdata;
    end
    if (wr_ok) begin
      nxt_unlock = mcirq_pkg::MCIRQ_UL_NONE;
      if (reg_addr == `MCIRQ_ADDR_PD_UNLOCK) begin
        if (reg_wdata == `MCIRQ_UNLOCK_CODE1) begin
          nxt_unlock = mcirq_pkg::MCIRQ_UL_FIRST;
        end else if (reg_wdata == `MCIRQ_UNLOCK_CODE2
                     && unlock_ff == mcirq_pkg::MCIRQ_UL_FIRST) begin
          nxt_unlock = mcirq_pkg::MCIRQ_UL_ARMED;
        end
      end else if (reg_addr == `MCIRQ_ADDR_PD_CTRL) begin
        if (!reg_wdata[`MCIRQ_PD_BIT]) begin
          nxt_pd = 1'b0;
        end else if (unlock_ff == mcirq_pkg::MCIRQ_UL_ARMED) begin
          nxt_pd = 1'b1;
        end
      end
    end
    // Pin follows the flags it will hold, so it is never a cycle stale
    nxt_int_oe = |(nxt_flags & nxt_int_en);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff  <= `MCIRQ_INT_REQ_RST;
      int_en_ff <= `MCIRQ_INT_EN_RST;
      unlock_ff <= mcirq_pkg::MCIRQ_UL_NONE;
      pd_ff     <= 1'b0;
      int_oe_ff <= 1'b0;
    end else begin
      flags_ff  <= nxt_flags;
      int_en_ff <= nxt_int_en;
      unlock_ff <= nxt_unlock;
      pd_ff     <= nxt_pd;
      int_oe_ff <= nxt_int_oe;
    end
  end

  assign int_n_o        = 1'b0;
  assign int_n_oe       = int_oe_ff;
  assign power_down_bit = pd_ff;
  // Read path, one cycle after the request
  assign rd_off = reg_addr - `MCIRQ_ADDR_RES_FIRST;
  assign rd_idx = rd_off[5:1];

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_en) begin
      case (reg_addr)
        `MCIRQ_ADDR_INT_EN:  nxt_rdata = int_en_ff;
        `MCIRQ_ADDR_INT_REQ: nxt_rdata = flags_ff;
        `MCIRQ_ADDR_PD_CTRL: nxt_rdata = {7'h00, pd_ff};
        `MCIRQ_ADDR_CELL:    nxt_rdata = {cell_busy, 2'b00, cell_cfg_ff};
        `MCIRQ_ADDR_TEMP:    nxt_rdata = {temp_busy, 2'b00, temp_cfg_ff[2], 2'b00,
                                          temp_cfg_ff[1:0]};
        `MCIRQ_ADDR_REGU:    nxt_rdata = {regu_busy, 7'h00};
        default: begin
          if (reg_addr >= `MCIRQ_ADDR_RES_FIRST && reg_addr <= `MCIRQ_ADDR_RES_LAST) begin
            nxt_rdata = reg_addr[0] ? res_mem[rd_idx][15:8] : res_mem[rd_idx][7:0];
          end else begin
            nxt_rdata = 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;
  // Checks
  property p_crc_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      crc_err |=> flags_ff[`MCIRQ_FLG_CRC] && $stable(int_en_ff);
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag or write drop");
  property p_set_masked;
    @(posedge clk_sys) disable iff (sys_rst)
      (id_done && !int_en_ff[`MCIRQ_FLG_ID]) |=> flags_ff[`MCIRQ_FLG_ID];
  endproperty
  a_set_masked: assert property (p_set_masked) else $error("flag not set when masked");
  property p_pin_level;
    @(posedge clk_sys) disable iff (sys_rst)
      int_n_oe == |(flags_ff & int_en_ff);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("interrupt pin mismatch");
  property p_write_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ok && reg_addr == `MCIRQ_ADDR_INT_REQ && !reg_wdata[`MCIRQ_FLG_ID] && !id_done)
      |=> !flags_ff[`MCIRQ_FLG_ID];
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("flag not cleared");
  property p_write_one;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ok && reg_addr == `MCIRQ_ADDR_INT_REQ && reg_wdata == 8'hFF)
      |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff));
  endproperty
  a_write_one: assert property (p_write_one) else $error("flag lost on write one");
  property p_release;
    @(posedge clk_sys) disable iff (sys_rst)
      (int_n_oe && (nxt_flags & nxt_int_en) == 8'h00) |=> !int_n_oe;
  endproperty
  a_release: assert property (p_release) else $error("pin not released");
  property p_pd_locked;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ok && reg_addr == `MCIRQ_ADDR_PD_CTRL && unlock_ff != mcirq_pkg::MCIRQ_UL_ARMED
       && !pd_ff) |=> !power_down_bit;
  endproperty
  a_pd_locked: assert property (p_pd_locked) else $error("power-down without unlock");
  property p_pd_unlock;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ok && reg_addr == `MCIRQ_ADDR_PD_CTRL && reg_wdata[`MCIRQ_PD_BIT]
       && unlock_ff == mcirq_pkg::MCIRQ_UL_ARMED) |=> power_down_bit;
  endproperty
  a_pd_unlock: assert property (p_pd_unlock) else $error("unlocked power-down refused");
  property p_cell_blocked;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ok && reg_addr == `MCIRQ_ADDR_CELL && reg_wdata[`MCIRQ_GO_BIT]
       && (temp_busy || regu_busy || open_short_busy)) |=> !cell_busy;
  endproperty
  a_cell_blocked: assert property (p_cell_blocked) else $error("cell start not blocked");
  property p_cell_frozen;
    @(posedge clk_sys) disable iff (sys_rst)
      (cell_busy && wr_ok && reg_addr == `MCIRQ_ADDR_CELL) |=> $stable(cell_cfg_ff);
  endproperty
  a_cell_frozen: assert property (p_cell_frozen) else $error("cell settings changed");
  property p_graceful_stop;
    @(posedge clk_sys) disable iff (sys_rst)
      (temp_busy && !adc_done && wr_ok && reg_addr == `MCIRQ_ADDR_TEMP
       && !reg_wdata[`MCIRQ_GO_BIT]) |=> temp_busy;
  endproperty
  a_graceful_stop: assert property (p_graceful_stop) else $error("stop cut conversion");
  property p_done_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(cell_busy) && $past(kind_ff) == mcirq_pkg::MCIRQ_KIND_CELL
      |-> flags_ff[`MCIRQ_FLG_CELL];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag missing");
  property p_regu_no_stop;
    @(posedge clk_sys) disable iff (sys_rst)
      (regu_busy && !adc_done) |=> regu_busy;
  endproperty
  a_regu_no_stop: assert property (p_regu_no_stop) else $error("regulator stopped early");
  c_cell_scan: cover property (@(posedge clk_sys) disable iff (sys_rst)
    cell_busy && chan_ff == 4'hF && seq_end);
  c_temp_stop: cover property (@(posedge clk_sys) disable iff (sys_rst)
    temp_busy && stop_ff && seq_end);
  c_pd_entry: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(power_down_bit));
  c_drop_return: cover property (@(posedge clk_sys) disable iff (sys_rst)
    flags_ff[`MCIRQ_FLG_DROP] && flags_ff[`MCIRQ_FLG_RETURN]);
endmodule

// File: verif/mcirq_adc_model.sv
// Converter model answering conversion requests after a set stall
`timescale 1ns/1ps

module mcirq_adc_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Converter handshake
  input  wire logic        adc_req,
  input  wire logic [1:0]  adc_kind,
  input  wire logic [3:0]  adc_chan,
  input  wire logic        adc_half,
  output logic             adc_done,
  output logic      [15:0] adc_data,
  // Stall length in cycles
  input  wire logic [7:0]  lat
);
  logic [7:0]  cnt_ff;
  logic        busy_ff;
  logic [15:0] last_ff;
  logic [15:0] val;

  // Result tags kind, channel and half flag so misrouted results show
  assign val = {4'h5, 1'b0, adc_half, adc_kind, 4'h0, adc_chan};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff   <= 8'h00;
      busy_ff  <= 1'b0;
      adc_done <= 1'b0;
      last_ff  <= 16'h0000;
      adc_data <= 16'hFFFF;
    end else begin
      adc_done <= 1'b0;
      // Stale data is inverted so it never passes for a fresh result
      adc_data <= ~last_ff;
      if (adc_req && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff  <= lat;
      end else if (busy_ff) begin
        if (cnt_ff == 8'h00) begin
          busy_ff  <= 1'b0;
          adc_done <= 1'b1;
          adc_data <= val;
          last_ff  <= val;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end
endmodule

// File: verif/tb_top.sv
// Self-checking testbench of the measurement control registers
`timescale 1ns/1ps

module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, crc_err = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, lat = 8'h03, rv;
  logic id_done = 1'b0, wdt_overflow = 1'b0, drop = 1'b0, os_busy = 1'b0;
  logic adc_req, adc_half, adc_done, int_n_o, int_n_oe, power_down_bit;
  logic [1:0] adc_kind;
  logic [3:0] adc_chan;
  logic [15:0] adc_data;
  logic [6:0] chq[$];
  int err_count = 0;
  int num_checks = 0;

  always #5 clk_sys = ~clk_sys;

  mcirq_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .crc_err(crc_err), .id_done(id_done),
    .wdt_overflow(wdt_overflow), .regulator_drop_pin(drop), .open_short_busy(os_busy),
    .adc_req(adc_req), .adc_kind(adc_kind), .adc_chan(adc_chan), .adc_half(adc_half),
    .adc_done(adc_done), .adc_data(adc_data), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
    .power_down_bit(power_down_bit));

  mcirq_adc_model i_adc (.clk_sys(clk_sys), .sys_rst(sys_rst), .adc_req(adc_req),
    .adc_kind(adc_kind), .adc_chan(adc_chan), .adc_half(adc_half),
    .adc_done(adc_done), .adc_data(adc_data), .lat(lat));

  // Log of every conversion request as kind, channel, half
  always @(posedge clk_sys) begin
    if (adc_req === 1'b1) begin
      chq.push_back({adc_kind, adc_chan, adc_half});
    end
  end

  function automatic logic [15:0] dat(input logic [1:0] k, input logic [3:0] c,
                                      input logic h);
    dat = {4'h5, 1'b0, h, k, 4'h0, c};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic c = 1'b0);
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    crc_err   = c;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    crc_err   = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    rd(a, rv);
    check(16'(rv), 16'(e));
  endtask

  task automatic wait_idle(input logic [6:0] a);
    int n;
    for (n = 0; n < 200; n++) begin
      rd(a, rv);
      if (rv[7] === 1'b0) begin
        break;
      end
    end
    if (n == 200) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, rv, 8'h00);
      wrap_up();
    end
  endtask

  // Compares logged requests and stored results against channel list
  task automatic res_chk(input logic [1:0] k, input int n, input logic h,
                         input logic [6:0] base, input logic [3:0] c0);
    logic [15:0] d;
    check(16'(chq.size()), 16'(n));
    for (int i = 0; i < n; i++) begin
      d = dat(k, c0 + 4'(i), h);
      check(16'(chq[i]), 16'({k, c0 + 4'(i), h}));
      rchk(base + 7'(2 * (c0 + i)), d[7:0]);
      rchk(base + 7'(2 * (c0 + i) + 1), d[15:8]);
    end
    chq.delete();
  endtask

  task automatic t_reset();
    rchk(7'h02, 8'h80);
    rchk(7'h03, 8'h00);
    rchk(7'h04, 8'h00);
    rchk(7'h05, 8'h00);
    rchk(7'h06, 8'h00);
    rchk(7'h07, 8'h00);
    rchk(7'h08, 8'h00);
    rchk(7'h10, 8'h00);
    check(16'(int_n_oe), 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_cell();
    wr(7'h06, 8'h92);
    rchk(7'h06, 8'h92);
    wr(7'h06, 8'h85);
    rchk(7'h06, 8'h92);
    wait_idle(7'h06);
    rchk(7'h06, 8'h12);
    rchk(7'h03, 8'h01);
    res_chk(2'h0, 3, 1'b0, 7'h20, 4'h0);
    lat = 8'h00;
    wr(7'h06, 8'h8F);
    wait_idle(7'h06);
    res_chk(2'h0, 1, 1'b0, 7'h20, 4'hF);
    lat = 8'h14;
    wr(7'h06, 8'h9F);
    wr(7'h06, 8'h1F);
    rchk(7'h06, 8'h9F);
    wait_idle(7'h06);
    check(16'(chq.size()), 16'h0001);
    chq.delete();
    $display("test cell done");
  endtask

  task automatic t_temp();
    lat = 8'h04;
    wr(7'h03, 8'h00);
    wr(7'h07, 8'h93);
    wr(7'h07, 8'h81);
    rchk(7'h07, 8'h93);
    wr(7'h06, 8'h80);
    wr(7'h08, 8'h80);
    rchk(7'h06, 8'h00);
    rchk(7'h08, 8'h00);
    wait_idle(7'h07);
    rchk(7'h03, 8'h02);
    res_chk(2'h1, 4, 1'b0, 7'h40, 4'h0);
    wr(7'h07, 8'h82);
    wait_idle(7'h07);
    res_chk(2'h1, 1, 1'b0, 7'h40, 4'h2);
    lat = 8'h14;
    wr(7'h07, 8'h93);
    wr(7'h07, 8'h13);
    rchk(7'h07, 8'h93);
    wait_idle(7'h07);
    check(16'(chq.size()), 16'h0001);
    chq.delete();
    $display("test temp done");
  endtask

  task automatic t_regu();
    wr(7'h03, 8'h00);
    wr(7'h08, 8'h80);
    wr(7'h08, 8'h00);
    rchk(7'h08, 8'h80);
    wr(7'h07, 8'h80);
    rchk(7'h07, 8'h00);
    wait_idle(7'h08);
    rchk(7'h03, 8'h04);
    res_chk(2'h2, 1, 1'b1, 7'h48, 4'h0);
    os_busy = 1'b1;
    wr(7'h06, 8'h80);
    rchk(7'h06, 8'h00);
    os_busy = 1'b0;
    $display("test regulator done");
  endtask

  task automatic t_irq();
    wr(7'h03, 8'h00);
    wr(7'h02, 8'h04);
    @(negedge clk_sys);
    id_done = 1'b1;
    @(negedge clk_sys);
    id_done = 1'b0;
    rchk(7'h03, 8'h08);
    check(16'(int_n_oe), 16'h0000);
    wr(7'h08, 8'h80);
    wait_idle(7'h08);
    chq.delete();
    check(16'(int_n_oe), 16'h0001);
    check(16'(int_n_o), 16'h0000);
    wr(7'h03, 8'hFB);
    rchk(7'h03, 8'h08);
    check(16'(int_n_oe), 16'h0000);
    wr(7'h02, 8'hFF, 1'b1);
    rchk(7'h02, 8'h04);
    rchk(7'h03, 8'h18);
    wr(7'h02, 8'h80);
    @(negedge clk_sys);
    wdt_overflow = 1'b1;
    @(negedge clk_sys);
    wdt_overflow = 1'b0;
    wr(7'h03, 8'h00);
    rchk(7'h03, 8'h80);
    check(16'(int_n_oe), 16'h0001);
    $display("test interrupt done");
  endtask

  task automatic t_drop();
    wr(7'h02, 8'h00);
    drop = 1'b1;
    repeat (5) @(negedge clk_sys);
    rchk(7'h03, 8'hA0);
    wr(7'h03, 8'hDF);
    repeat (5) @(negedge clk_sys);
    rchk(7'h03, 8'h80);
    drop = 1'b0;
    repeat (5) @(negedge clk_sys);
    rchk(7'h03, 8'hC0);
    drop = 1'b1;
    repeat (5) @(negedge clk_sys);
    rchk(7'h03, 8'hE0);
    wr(7'h03, 8'hFF);
    rchk(7'h03, 8'hE0);
    $display("test drop done");
  endtask

  task automatic t_pd();
    wr(7'h05, 8'h01);
    check(16'(power_down_bit), 16'h0000);
    wr(7'h04, 8'h55);
    wr(7'h04, 8'hAA);
    wr(7'h05, 8'h01);
    check(16'(power_down_bit), 16'h0001);
    rchk(7'h05, 8'h01);
    wr(7'h05, 8'h00);
    check(16'(power_down_bit), 16'h0000);
    wr(7'h04, 8'h55);
    wr(7'h02, 8'h00);
    wr(7'h04, 8'hAA);
    wr(7'h05, 8'h01);
    check(16'(power_down_bit), 16'h0000);
    $display("test power-down done");
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_cell();
    t_temp();
    t_regu();
    t_irq();
    t_drop();
    t_pd();
    wrap_up();
  end
endmodule
